/* File: hw/switch_node_pkg.sv */
// Constants of the switch node configuration bank and routing lookup.
// Assumes the PLL clock is the module clock; register numbers are word indices.
package switch_node_pkg;

    // ----------------------------------------------------------------
    // Register numbers
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_DEVICE_ID   = 8'h00;
    localparam logic [7:0] REG_SWITCH_DESC = 8'h01;
    localparam logic [7:0] REG_SECURITY    = 8'h04;
    localparam logic [7:0] REG_NODE_ID     = 8'h05;
    localparam logic [7:0] REG_PLL         = 8'h06;
    localparam logic [7:0] REG_SWITCH_DIV  = 8'h07;
    localparam logic [7:0] REG_REF_DIV     = 8'h08;
    localparam logic [7:0] REG_DIR_LOW     = 8'h0C;
    localparam logic [7:0] REG_DIR_HIGH    = 8'h0D;
    localparam logic [7:0] REG_LINK_FIRST  = 8'h20;
    localparam logic [7:0] REG_LINK_LAST   = 8'h27;

    // ----------------------------------------------------------------
    // Field positions and write masks
    // ----------------------------------------------------------------
    localparam int         SEC_WRITE_LOCK_BIT = 31;
    localparam int         SEC_PLL_LOCK_BIT   = 8;
    localparam int         SEC_HEADER_BIT     = 0;
    localparam logic [31:0] SEC_WMASK         = 32'h8000_0101;
    localparam logic [31:0] PLL_WMASK         = 32'h039F_FF7F;
    localparam int         ID_CHIP_LSB        = 24;
    localparam int         ID_PINS_LSB        = 16;
    localparam int         ID_REV_LSB         = 8;
    localparam int         DESC_LINKS_LSB     = 16;
    localparam int         DESC_CORES_LSB     = 8;
    localparam int         LINK_DIR_LSB       = 8;
    localparam int         DIR_W              = 4;
    localparam int         NUM_LINKS          = 8;

    // ----------------------------------------------------------------
    // Identity and description (identity values are arbitrary)
    // ----------------------------------------------------------------
    localparam logic [7:0] CHIP_ID          = 8'h5A;
    localparam logic [7:0] SWITCH_REVISION  = 8'h01;
    localparam logic [7:0] SWITCH_VERSION   = 8'h02;
    localparam logic [7:0] NUM_SWITCH_LINKS = 8'h08;
    localparam logic [7:0] NUM_CORES        = 8'h01;
    localparam logic [7:0] LINKS_PER_CORE   = 8'h04;

    // ----------------------------------------------------------------
    // Reset values and counts
    // ----------------------------------------------------------------
    localparam logic [15:0] SWITCH_DIV_RST = 16'h0000;
    localparam logic [15:0] REF_DIV_RST    = 16'h0003;
    localparam int          REF_TARGET_MHZ = 100;
    localparam logic [1:0]  BOOT_CAPTURE_CYCLES = 2'h2;
    // PLL value loaded at boot, indexed by {pin_b, pin_a}
    localparam logic [3:0][31:0] PLL_PRESET = {32'h0181_3F01, 32'h0101_2F01,
                                               32'h0080_1F00, 32'h0000_0F00};

endpackage

/* File: hw/div_if.sv */
// Carrier between the configuration bank and one clock-tick divider.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface div_if;
    logic [15:0] div;
    logic        tick;
    modport ctrl (output div, input tick);
    modport core (input div, output tick);
endinterface
`default_nettype wire

/* File: hw/clock_tick_divider.sv */
// Divides the module clock by div+1 and emits a one-cycle tick.
// Assumes the module clock stands in for the PLL clock.
`timescale 1ns/1ps
`default_nettype none
module clock_tick_divider
(
    // Clock, reset, enable
    input  wire logic clk_sys_i,
    input  wire logic resetn_i,
    input  wire logic ce_i,
    // Divider value in, tick out
    div_if.core       port
);
    typedef struct packed
    {
        logic [15:0] cnt;
        logic        tick;
    } div_state_t;

    div_state_t q;
    div_state_t d;

    always_comb
    begin
        d      = q;
        d.tick = 1'b0;
        // Compare with >= so a smaller value written mid-count takes at once
        if (q.cnt >= port.div)
        begin
            d.cnt  = 16'h0000;
            d.tick = 1'b1;
        end
        else
        begin
            d.cnt = q.cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
            q <= '0;
        else if (ce_i)
            q <= d;
    end

    assign port.tick = q.tick;

    a_div_zero_tick: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (ce_i && $past(ce_i) && $past(resetn_i) && port.div == 16'h0000 && $past(port.div) == 16'h0000)
            |-> port.tick)
        else $error("divider by one did not tick every cycle");
    a_tick_restart: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (ce_i && port.tick && port.div != 16'h0000) |=> (!port.tick && q.cnt == 16'h0001))
        else $error("divider count not restarted after tick");
endmodule
`default_nettype wire

/* File: hw/switch_node_config_routing.sv */
// Configuration register bank and routing lookup of a switch node.
// Assumes config requests and packet lookups come from logic on clk_sys_i;
// the boot-select pins are asynchronous and are synchronised here.
//
// Notes on behaviour
// - Registers are reached only by config read/write requests to this node.
// - Identity: chip id 31:24, zero 23:18, boot pins 17:16, revision 15:8, version 7:0.
// - Description: switch links 23:16, attached cores 15:8, links per core 7:0.
// - Security bit 31 set blocks every write to this bank; resets to zero.
// - Security bit 8 set blocks updates of the PLL register; resets to zero.
// - Security bit 0 selects one-byte headers; all nodes must agree.
// - Node identifier is 16 bits, resets zero, compared from its top bit.
// - A write to the PLL register that neither lock bit blocks resets the processor tile.
// - PLL register: output divider 25:23, multiplier 20:8, input divider 6:0.
// - Switch clock is PLL clock divided by divider value plus one.
// - Reference clock is PLL clock divided by ref value plus one; reset 3.
// - Foreign packets go in the direction of the top mismatching bit.
// - Low table: bit n direction in fields 4n+3..4n for bits 0..7.
// - High table: bit 8 in 3:0 up to bit 15 in 31:28.
// - Each link holds a 4-bit direction at 11:8; packets go on matching links.
`timescale 1ns/1ps
`default_nettype none
module switch_node_config_routing
(
    // Clock, reset, enable
    input  wire logic        clk_sys_i,
    input  wire logic        resetn_i,
    input  wire logic        ce_i,
    // Boot-select pins (asynchronous)
    input  wire logic        boot_select_pin_a_i,
    input  wire logic        boot_select_pin_b_i,
    // Configuration requests
    input  wire logic        cfg_req_i,
    input  wire logic        cfg_write_i,
    input  wire logic [7:0]  cfg_addr_i,
    input  wire logic [31:0] cfg_wdata_i,
    output logic             cfg_ack_o,
    output logic [31:0]      cfg_rdata_o,
    // Packet routing lookup
    input  wire logic        pkt_valid_i,
    input  wire logic [15:0] pkt_dest_i,
    output logic             route_valid_o,
    output logic             route_local_o,
    output logic [3:0]       route_dir_o,
    output logic [7:0]       route_links_o,
    // Node controls
    output logic             header_one_byte_o,
    output logic [31:0]      pll_settings_o,
    output logic             tile_reset_o,
    output logic             switch_clk_en_o,
    output logic             ref_clk_en_o
);

    typedef struct packed
    {
        logic [1:0]       pin_a_sync;
        logic [1:0]       pin_b_sync;
        logic [1:0]       cap_cnt;
        logic             captured;
        logic [1:0]       boot_pins;
        logic [31:0]      security;
        logic [15:0]      node_id;
        logic [31:0]      pll;
        logic [15:0]      sw_div;
        logic [15:0]      ref_div;
        logic [31:0]      dir_low;
        logic [31:0]      dir_high;
        logic [7:0][3:0]  link_dir;
        logic [31:0]      rdata;
        logic             ack;
        logic             tile_reset;
        logic             route_valid;
        logic             route_local;
        logic [3:0]       route_dir;
        logic [7:0]       route_links;
    } node_state_t;

    localparam node_state_t RESET_STATE = '{ref_div: switch_node_pkg::REF_DIV_RST,
                                            sw_div:  switch_node_pkg::SWITCH_DIV_RST,
                                            default: '0};

    node_state_t q;
    node_state_t d;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [3:0] msb_index(input logic [15:0] v);
        logic [3:0] idx;
        idx = 4'h0;
        for (int i = 0; i < 16; i++)
        begin
            if (v[i])
                idx = 4'(i);
        end
        return idx;
    endfunction

    function automatic logic [3:0] dir_field(input logic [31:0] tbl, input logic [2:0] sel);
        return tbl[{sel, 2'b00} +: switch_node_pkg::DIR_W];
    endfunction

    function automatic logic is_link_reg(input logic [7:0] a);
        return (a >= switch_node_pkg::REG_LINK_FIRST) && (a <= switch_node_pkg::REG_LINK_LAST);
    endfunction

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    logic [15:0] mismatch;
    logic [3:0]  top_bit;
    logic [3:0]  dir_sel;
    logic [2:0]  link_sel;
    logic        wr_allowed;

    always_comb
    begin
        d          = q;
        d.ack      = 1'b0;
        d.tile_reset = 1'b0;
        d.route_valid = 1'b0;
        link_sel   = cfg_addr_i[2:0];
        wr_allowed = cfg_req_i && cfg_write_i && !q.security[switch_node_pkg::SEC_WRITE_LOCK_BIT];

        // Boot pins: second flop only, caught once after release
        d.pin_a_sync = {q.pin_a_sync[0], boot_select_pin_a_i};
        d.pin_b_sync = {q.pin_b_sync[0], boot_select_pin_b_i};
        if (!q.captured)
        begin
            if (q.cap_cnt == switch_node_pkg::BOOT_CAPTURE_CYCLES)
            begin
                d.captured  = 1'b1;
                d.boot_pins = {q.pin_b_sync[1], q.pin_a_sync[1]};
                d.pll       = switch_node_pkg::PLL_PRESET[{q.pin_b_sync[1], q.pin_a_sync[1]}];
            end
            else
            begin
                d.cap_cnt = q.cap_cnt + 2'h1;
            end
        end

        // Config requests answered one cycle later
        if (cfg_req_i)
        begin
            d.ack   = 1'b1;
            d.rdata = 32'h0000_0000;
            if (!cfg_write_i)
            begin
                unique case (1'b1)
                    cfg_addr_i == switch_node_pkg::REG_DEVICE_ID:
                        d.rdata = {switch_node_pkg::CHIP_ID, 6'h00, q.boot_pins,
                                   switch_node_pkg::SWITCH_REVISION,
                                   switch_node_pkg::SWITCH_VERSION};
                    cfg_addr_i == switch_node_pkg::REG_SWITCH_DESC:
                        d.rdata = {8'h00, switch_node_pkg::NUM_SWITCH_LINKS,
                                   switch_node_pkg::NUM_CORES,
                                   switch_node_pkg::LINKS_PER_CORE};
                    cfg_addr_i == switch_node_pkg::REG_SECURITY:
                        d.rdata = q.security;
                    cfg_addr_i == switch_node_pkg::REG_NODE_ID:
                        d.rdata = {16'h0000, q.node_id};
                    cfg_addr_i == switch_node_pkg::REG_PLL:
                        d.rdata = q.pll;
                    cfg_addr_i == switch_node_pkg::REG_SWITCH_DIV:
                        d.rdata = {16'h0000, q.sw_div};
                    cfg_addr_i == switch_node_pkg::REG_REF_DIV:
                        d.rdata = {16'h0000, q.ref_div};
                    cfg_addr_i == switch_node_pkg::REG_DIR_LOW:
                        d.rdata = q.dir_low;
                    cfg_addr_i == switch_node_pkg::REG_DIR_HIGH:
                        d.rdata = q.dir_high;
                    is_link_reg(cfg_addr_i):
                        d.rdata = {20'h00000, q.link_dir[link_sel], 8'h00};
                    default:
                        d.rdata = 32'h0000_0000;
                endcase
            end
        end

        // Writes; locked bank drops them silently
        if (wr_allowed)
        begin
            unique case (1'b1)
                cfg_addr_i == switch_node_pkg::REG_SECURITY:
                    d.security = cfg_wdata_i & switch_node_pkg::SEC_WMASK;
                cfg_addr_i == switch_node_pkg::REG_NODE_ID:
                    d.node_id = cfg_wdata_i[15:0];
                cfg_addr_i == switch_node_pkg::REG_PLL:
                begin
                    if (!q.security[switch_node_pkg::SEC_PLL_LOCK_BIT])
                    begin
                        d.pll        = cfg_wdata_i & switch_node_pkg::PLL_WMASK;
                        d.tile_reset = 1'b1;
                    end
                end
                cfg_addr_i == switch_node_pkg::REG_SWITCH_DIV:
                    d.sw_div = cfg_wdata_i[15:0];
                cfg_addr_i == switch_node_pkg::REG_REF_DIV:
                    d.ref_div = cfg_wdata_i[15:0];
                cfg_addr_i == switch_node_pkg::REG_DIR_LOW:
                    d.dir_low = cfg_wdata_i;
                cfg_addr_i == switch_node_pkg::REG_DIR_HIGH:
                    d.dir_high = cfg_wdata_i;
                is_link_reg(cfg_addr_i):
                    d.link_dir[link_sel] = cfg_wdata_i[switch_node_pkg::LINK_DIR_LSB +: 4];
                default:
                    d.security = q.security;
            endcase
        end

        // Routing lookup, result one cycle later
        mismatch = pkt_dest_i ^ q.node_id;
        top_bit  = msb_index(mismatch);
        dir_sel  = top_bit[3] ? dir_field(q.dir_high, top_bit[2:0])
                              : dir_field(q.dir_low, top_bit[2:0]);
        if (pkt_valid_i)
        begin
            d.route_valid = 1'b1;
            d.route_local = (mismatch == 16'h0000);
            d.route_dir   = (mismatch == 16'h0000) ? 4'h0 : dir_sel;
            for (int l = 0; l < switch_node_pkg::NUM_LINKS; l++)
            begin
                d.route_links[l] = (mismatch != 16'h0000) && (q.link_dir[l] == dir_sel);
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
            q <= RESET_STATE;
        else if (ce_i)
            q <= d;
    end

    // ----------------------------------------------------------------
    // Clock tick dividers
    // ----------------------------------------------------------------
    div_if sw_div_if ();
    div_if ref_div_if ();

    assign sw_div_if.div  = q.sw_div;
    assign ref_div_if.div = q.ref_div;

    clock_tick_divider u_switch_div
    (
        .clk_sys_i (clk_sys_i),
        .resetn_i  (resetn_i),
        .ce_i      (ce_i),
        .port      (sw_div_if.core)
    );

    clock_tick_divider u_ref_div
    (
        .clk_sys_i (clk_sys_i),
        .resetn_i  (resetn_i),
        .ce_i      (ce_i),
        .port      (ref_div_if.core)
    );

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign cfg_ack_o         = q.ack;
    assign cfg_rdata_o       = q.rdata;
    assign route_valid_o     = q.route_valid;
    assign route_local_o     = q.route_local;
    assign route_dir_o       = q.route_dir;
    assign route_links_o     = q.route_links;
    assign header_one_byte_o = q.security[switch_node_pkg::SEC_HEADER_BIT];
    assign pll_settings_o    = q.pll;
    assign tile_reset_o      = q.tile_reset;
    assign switch_clk_en_o   = sw_div_if.tick;
    assign ref_clk_en_o      = ref_div_if.tick;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_write_to(logic [7:0] a);
        ce_i && cfg_req_i && cfg_write_i && cfg_addr_i == a;
    endsequence

    sequence s_read_of(logic [7:0] a);
        ce_i && cfg_req_i && !cfg_write_i && cfg_addr_i == a;
    endsequence

    a_write_lock: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (ce_i && cfg_req_i && cfg_write_i && q.security[31]) |=> ($stable(q.node_id) && $stable(q.pll)
            && $stable(q.dir_low) && $stable(q.security) && !tile_reset_o))
        else $error("write accepted while bank locked");
    a_pll_lock: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (s_write_to(switch_node_pkg::REG_PLL) and (q.security[8] && q.captured)) |=> $stable(q.pll))
        else $error("PLL register changed while PLL lock set");
    a_pll_tile_reset: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (s_write_to(switch_node_pkg::REG_PLL) and (!q.security[31] && !q.security[8]))
            |=> ((tile_reset_o && pll_settings_o == ($past(cfg_wdata_i) & switch_node_pkg::PLL_WMASK))
            ##1 (!tile_reset_o || !$past(ce_i)
                || $past(cfg_req_i && cfg_write_i && cfg_addr_i == switch_node_pkg::REG_PLL))))
        else $error("PLL write did not pulse tile reset");
    a_id_fields: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        s_read_of(switch_node_pkg::REG_DEVICE_ID) |=> (cfg_ack_o && cfg_rdata_o[31:24] == 8'h5A
            && cfg_rdata_o[23:18] == 6'h00 && cfg_rdata_o[15:0] == 16'h0102))
        else $error("identity read wrong");
    a_desc_fields: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        s_read_of(switch_node_pkg::REG_SWITCH_DESC) |=> (cfg_ack_o && cfg_rdata_o == 32'h0008_0104))
        else $error("description read wrong");
    a_node_id_read: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        s_read_of(switch_node_pkg::REG_NODE_ID) |=> (cfg_ack_o && cfg_rdata_o[31:16] == 16'h0000
            && cfg_rdata_o[15:0] == $past(q.node_id)))
        else $error("node identifier read wrong");
    a_route_local: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (ce_i && pkt_valid_i && pkt_dest_i == q.node_id) |=> (route_valid_o && route_local_o
            && route_links_o == 8'h00))
        else $error("matching packet not delivered locally");
    a_route_top_bit: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (ce_i && pkt_valid_i && pkt_dest_i[15] != q.node_id[15]) |=> (!route_local_o
            && route_dir_o == $past(q.dir_high[31:28])))
        else $error("top mismatch bit not routed by high table");
    a_route_bit_zero: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (ce_i && pkt_valid_i && (pkt_dest_i ^ q.node_id) == 16'h0001) |=>
            (route_dir_o == $past(q.dir_low[3:0])))
        else $error("bit zero mismatch not routed by low table");
    a_link_select: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (ce_i && pkt_valid_i && pkt_dest_i != q.node_id) |=>
            (route_links_o[3] == ($past(q.link_dir[3]) == route_dir_o)))
        else $error("link selection disagrees with link direction");
endmodule
`default_nettype wire

/* File: sim/packet_source_model.sv */
// Packet source standing for a neighbouring node: one lookup per send.
// Assumes the bench calls send; send changes land on falling edges, idle churn on rising edges.
`timescale 1ns/1ps
`default_nettype none
module packet_source_model
(
    // Clock
    input  wire logic   clk_sys_i,
    // Lookup request
    output logic        pkt_valid_o,
    output logic [15:0] pkt_dest_o
);
    initial
    begin
        pkt_valid_o = 1'b0;
        pkt_dest_o  = 16'h0000;
    end
    // Idle destination churns so a stale value never looks valid
    always @(posedge clk_sys_i)
        if (!pkt_valid_o)
            pkt_dest_o <= pkt_dest_o + 16'h1357;
    task automatic send(input logic [15:0] d);
        @(negedge clk_sys_i);
        pkt_valid_o = 1'b1;
        pkt_dest_o  = d;
        @(negedge clk_sys_i);
        pkt_valid_o = 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: sim/tb_switch_node_config_routing.sv */
// Self-checking bench: register model and routing model against the node.
// Assumes 250 MHz clock, one-cycle answers, boot capture before edge 4.
`timescale 1ns/1ps
`default_nettype none
module tb_switch_node_config_routing;
    logic        clk_sys_i, resetn_i, pin_a, pin_b, req, wr, ack, pv, rv, rl;
    logic        hdr, trst, sw_en, ref_en;
    logic [7:0]  addr, rlinks;
    logic [31:0] wdata, rdata, pll;
    logic [15:0] pd;
    logic [3:0]  rdir;
    int          err_total, num_checks, seed, i, c1, c2;
    int          m[64];
    packet_source_model src (.clk_sys_i(clk_sys_i), .pkt_valid_o(pv), .pkt_dest_o(pd));
    switch_node_config_routing uut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .ce_i(1'b1),
        .boot_select_pin_a_i(pin_a), .boot_select_pin_b_i(pin_b), .cfg_req_i(req),
        .cfg_write_i(wr), .cfg_addr_i(addr), .cfg_wdata_i(wdata), .cfg_ack_o(ack),
        .cfg_rdata_o(rdata), .pkt_valid_i(pv), .pkt_dest_i(pd), .route_valid_o(rv),
        .route_local_o(rl), .route_dir_o(rdir), .route_links_o(rlinks),
        .header_one_byte_o(hdr), .pll_settings_o(pll), .tile_reset_o(trst),
        .switch_clk_en_o(sw_en), .ref_clk_en_o(ref_en));
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    function automatic logic [31:0] wmask(input int a);
        if (a == 4) return switch_node_pkg::SEC_WMASK;
        if (a == 6) return switch_node_pkg::PLL_WMASK;
        if (a == 5 || a == 7 || a == 8) return 32'h0000_FFFF;
        if (a == 12 || a == 13) return 32'hFFFF_FFFF;
        if (a >= 32 && a < 40) return 32'h0000_0F00;
        return 32'h0000_0000;
    endfunction
    // Register access; answer and side effects looked at one cycle on
    task automatic cfg(input logic w, input int a, input logic [31:0] d);
        logic ok;
        ok = wmask(a) != 0 && !m[4][31] && !(a == 6 && m[4][8]);
        @(negedge clk_sys_i);
        req   = 1'b1;
        wr    = w;
        addr  = 8'(a);
        wdata = d;
        @(negedge clk_sys_i);
        req = 1'b0;
        chk("ack", ack, 1);
        if (w)
        begin
            chk("tile_reset", trst, w && ok && a == 6);
            if (ok)
                m[a] = d & wmask(a);
        end
        else
            chk("rdata", rdata, m[a]);
        chk("pll_out", pll, m[6]);
        chk("header", hdr, m[4][0]);
    endtask
    task automatic look(input logic [15:0] d);
        logic [15:0] x;
        logic [3:0]  dir;
        logic [7:0]  lk;
        x   = d ^ m[5][15:0];
        dir = 4'h0;
        lk  = 8'h00;
        for (int k = 0; k < 16; k++)
            if (x[k])
                dir = 4'(m[k < 8 ? 12 : 13] >> (4 * (k % 8)));
        for (int l = 0; l < 8; l++)
            lk[l] = x != 0 && m[32 + l][11:8] == dir;
        src.send(d);
        chk("route_valid", rv, 1);
        chk("route_local", rl, x == 0);
        chk("route_dir", rdir, dir);
        chk("route_links", rlinks, lk);
    endtask
    initial
    begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end
    initial
    begin
        repeat (20000) @(posedge clk_sys_i);
        err_total++;
        test_done();
    end
    initial
    begin
        seed = 63;
        {resetn_i, req, wr, addr, wdata, err_total, num_checks} = '0;
        pin_a = 1'($random(seed));
        pin_b = 1'($random(seed));
        m[0] = {switch_node_pkg::CHIP_ID, 6'h00, pin_b, pin_a, switch_node_pkg::SWITCH_REVISION,
                switch_node_pkg::SWITCH_VERSION};
        m[1] = {8'h00, switch_node_pkg::NUM_SWITCH_LINKS, switch_node_pkg::NUM_CORES,
                switch_node_pkg::LINKS_PER_CORE};
        m[6] = switch_node_pkg::PLL_PRESET[{pin_b, pin_a}];
        m[8] = 3;
        repeat (3) @(negedge clk_sys_i);
        resetn_i = 1'b1;
        repeat (5) @(negedge clk_sys_i);
        // ----------------------------------------------------------------
        // Reset values, random writes, read back, lookups
        // ----------------------------------------------------------------
        for (i = 0; i < 42; i++)
            cfg(0, i, 0);
        for (i = 0; i < 42; i++)
            cfg(1, i, i == 4 ? 32'h0000_0001 : $random(seed));
        for (i = 0; i < 42; i++)
            cfg(0, i, 0);
        for (i = 0; i < 40; i++)
            look(16'($random(seed)));
        look(m[5][15:0]);
        look(m[5][15:0] ^ 16'h8000);
        look(m[5][15:0] ^ 16'h0001);
        // Divider periods of 3 and 5 over 30 cycles
        cfg(1, 7, 2);
        cfg(1, 8, 4);
        {c1, c2} = '0;
        repeat (30)
        begin
            @(negedge clk_sys_i);
            c1 += sw_en;
            c2 += ref_en;
        end
        chk("switch_ticks", c1, 10);
        chk("ref_ticks", c2, 6);
        // PLL lock, then bank lock
        cfg(1, 4, 32'h0000_0100);
        cfg(1, 6, $random(seed));
        cfg(1, 4, 32'hFFFF_FFFF);
        for (i = 4; i < 14; i++)
            cfg(1, i, $random(seed));
        for (i = 4; i < 14; i++)
            cfg(0, i, 0);
        test_done();
    end
endmodule
`default_nettype wire
